// ===== testbench/cfrsc_assertions.sv
/* Port checker for the fetch, reset and sleep control.
 Bound to cfrsc_top from the bench top; one clock. */
`timescale 1ns/1ps
module cfrsc_assertions (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        reset_pin,
   input wire logic        sleep_pin,
   input wire logic [11:0] address,
   input wire logic        bram_enable,
   input wire logic        exec_phase,
   input wire logic        write_strobe,
   input wire logic        read_strobe,
   input wire logic        bank_sel,
   input wire logic        int_enable
);
   // Windows allow two sync flops plus finishing an instruction
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_alt; exec_phase |=> !exec_phase; endproperty
   a_alt: assert property (p_alt) else $error("exec twice");
   property p_stb; write_strobe || read_strobe |-> exec_phase; endproperty
   a_stb: assert property (p_stb) else $error("strobe outside exec");
   property p_rst; reset_pin [*4] |-> address == 12'h000 && !bram_enable
      && !write_strobe && !read_strobe; endproperty
   a_rst: assert property (p_rst) else $error("reset not held");
   property p_init; reset_pin [*4] |-> !bank_sel && !int_enable; endproperty
   a_init: assert property (p_init) else $error("start state");
   property p_en; exec_phase |-> !bram_enable; endproperty
   a_en: assert property (p_en) else $error("enable in exec");
   property p_slp; (sleep_pin && !reset_pin) [*6] |-> !bram_enable
      && !write_strobe && !read_strobe; endproperty
   a_slp: assert property (p_slp) else $error("sleep active");
   property p_hold; (sleep_pin && !reset_pin) [*7] |=> $stable(address); endproperty
   a_hold: assert property (p_hold) else $error("sleep addr");
   // Address must stand through the edge at which the memory reads it
   property p_fst; !exec_phase && bram_enable && !$past(reset_pin, 2) |=> $stable(address);
      endproperty
   a_fst: assert property (p_fst) else $error("fetch addr");
endmodule // cfrsc_assertions

// ===== testbench/cfrsc_prog_mem.sv
/* Synchronous program memory model.
 Word is a pattern of the address so the bench can predict it. */
`timescale 1ns/1ps
module cfrsc_prog_mem (
   input  wire logic        ref_clk,
   input  wire logic [11:0] address,
   input  wire logic        bram_enable,
   output logic      [17:0] instruction
);
   // Disabled memory holds its last word, as a real one does
   always_ff @(posedge ref_clk) begin
      if (bram_enable) begin
         instruction <= {6'h2D, address};
      end
   end
endmodule // cfrsc_prog_mem

// ===== testbench/cfrsc_top_tb.sv
/* Self-checking bench for cfrsc_top.
 Drives inputs at the falling edge; memory model on the far side. */
`timescale 1ns/1ps
module cfrsc_top_tb;
   import cfrsc_pkg::*;
   logic        ref_clk, rst, reset_pin, sleep_pin, write_req, read_req, wq, rq;
   logic        bram_enable, exec_phase, write_strobe, read_strobe, bank_sel, int_enable;
   logic [11:0] next_addr, address, fa, held;
   logic        ir_due;
   logic [17:0] instruction, instr_word;
   int          err_total = 0;
   int          cmp_count = 0;
   cfrsc_top i_cfrsc_top (.ref_clk(ref_clk), .rst(rst), .reset_pin(reset_pin),
      .sleep_pin(sleep_pin), .instruction(instruction), .next_addr(next_addr),
      .write_req(write_req), .read_req(read_req), .address(address),
      .bram_enable(bram_enable), .instr_word(instr_word), .exec_phase(exec_phase),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .bank_sel(bank_sel),
      .int_enable(int_enable));
   cfrsc_prog_mem i_cfrsc_prog_mem (.ref_clk(ref_clk), .address(address),
      .bram_enable(bram_enable), .instruction(instruction));
   function automatic logic [17:0] word_of(logic [11:0] a);
      return {6'h2D, a};
   endfunction
   task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait for a fetch cycle; a hang ends the run
   task automatic wait_fetch();
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!(bram_enable === 1'b1 && exec_phase === 1'b0) && n < 20);
      if (!(bram_enable === 1'b1 && exec_phase === 1'b0)) begin
         err_total++;
         conclude();
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Pre-edge values: strobes stand in EXEC, the word lands at its end
   always @(posedge ref_clk) begin
      if (!rst && exec_phase === 1'b1) begin
         check("strobes", {16'h0, write_strobe, read_strobe}, {16'h0, wq, rq});
         ir_due = 1'b1;
      end else begin
         if (ir_due === 1'b1) begin
            check("instr_word", instr_word, word_of(fa));
         end
         ir_due = 1'b0;
         if (bram_enable === 1'b1) begin
            fa = address;
            wq = write_req;
            rq = read_req;
         end
      end
   end
   initial begin
      rst = 1'b1; reset_pin = 1'b0; sleep_pin = 1'b0;
      next_addr = 12'h000; write_req = 1'b0; read_req = 1'b0;
      void'($urandom(32'h1489));
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      wait_fetch();
      check("boot", {4'h0, bank_sel, int_enable, address}, 18'h0);
      for (int i = 0; i < 60; i++) begin
         @(negedge ref_clk);
         next_addr = (i == 9) ? 12'hFFF : 12'($urandom);
         write_req = 1'($urandom);
         read_req = 1'($urandom);
      end
      wait_fetch();
      sleep_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      held = address;
      // Inputs other than reset must be ignored in sleep
      for (int i = 0; i < 4; i++) begin
         next_addr = 12'($urandom);
         write_req = 1'b1;
         @(negedge ref_clk);
         check("sleep", {3'h0, bram_enable, write_strobe, read_strobe, address},
            {6'h0, held});
      end
      sleep_pin = 1'b0;
      wait_fetch();
      check("resume", {6'h0, address}, {6'h0, held});
      sleep_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      reset_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("rst", {5'h0, bram_enable, address}, 18'h0);
      reset_pin = 1'b0;
      sleep_pin = 1'b0;
      wait_fetch();
      check("restart", {6'h0, address}, 18'h0);
      conclude();
   end
endmodule // cfrsc_top_tb
bind cfrsc_top cfrsc_assertions i_cfrsc_assertions (.ref_clk(ref_clk), .rst(rst),
   .reset_pin(reset_pin), .sleep_pin(sleep_pin), .address(address),
   .bram_enable(bram_enable), .exec_phase(exec_phase), .write_strobe(write_strobe),
   .read_strobe(read_strobe), .bank_sel(bank_sel), .int_enable(int_enable));

// ===== verilog/cfrsc_if.sv
/*
 Interface carrying the two-flop synchronised inputs from the synchroniser
 to the controller. Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface cfrsc_sync_if;
   logic rst_req;
   logic sleep_req;
   modport src (output rst_req, output sleep_req);
   modport dst (input rst_req, input sleep_req);
endinterface

// ===== verilog/cfrsc_pkg.sv
/*
 Shared constants and state encoding for the fetch, reset and sleep control.
 Assumes a single 20 MHz clock and a synchronous program memory.
*/
package cfrsc_pkg;
   localparam int ADDR_W = 12;
   localparam int INSTR_W = 18;
   localparam logic [11:0] RESET_ADDR = 12'h000;
   localparam logic [11:0] ADDR_STEP = 12'h001;
   localparam logic [1:0] START_CYCLES = 2'h2;
   localparam logic [1:0] START_ZERO = 2'h0;
   localparam logic [1:0] START_ONE = 2'h1;
   // Run states, one-hot
   typedef enum logic [4:0] {
      CFRSC_RESET = 5'h01,
      CFRSC_START = 5'h02,
      CFRSC_FETCH = 5'h04,
      CFRSC_EXEC  = 5'h08,
      CFRSC_SLEEP = 5'h10
   } cfrsc_state_e;
endpackage

// ===== verilog/cfrsc_sync.sv
/*
 Two-flop synchronisers for the reset request and sleep pins.
 Assumes both pins may come from outside the ref_clk domain.
*/
`timescale 1ns/1ps
module cfrsc_sync (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic reset_pin,
   input  wire logic sleep_pin,
   cfrsc_sync_if.src sync
);
   logic [1:0] meta_q;
   logic [1:0] meta_d;
   logic [1:0] stab_q;
   logic [1:0] stab_d;

   // Next values: first stage only feeds the second
   always_comb begin
      meta_d = {sleep_pin, reset_pin};
      stab_d = meta_q;
   end

   // Reset pulls the reset request high so start-up follows configuration
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 2'h1;
         stab_q <= 2'h1;
      end else begin
         meta_q <= meta_d;
         stab_q <= stab_d;
      end
   end

   assign sync.rst_req   = stab_q[0];
   assign sync.sleep_req = stab_q[1];
endmodule // cfrsc_sync

// ===== verilog/cfrsc_top.sv
/*
 Program fetch, reset start-up and sleep control of a small 8-bit core.
 Assumes a synchronous program memory with one cycle read latency, and an
 execution datapath that supplies the next address and strobe requests.
*/
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module cfrsc_top
   import cfrsc_pkg::*;
(
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         reset_pin,
   input  wire logic                         sleep_pin,
   input  wire logic [cfrsc_pkg::INSTR_W-1:0] instruction,
   input  wire logic [cfrsc_pkg::ADDR_W-1:0]  next_addr,
   input  wire logic                         write_req,
   input  wire logic                         read_req,
   output logic      [cfrsc_pkg::ADDR_W-1:0]  address,
   output logic                              bram_enable,
   output logic      [cfrsc_pkg::INSTR_W-1:0] instr_word,
   output logic                              exec_phase,
   output logic                              write_strobe,
   output logic                              read_strobe,
   output logic                              bank_sel,
   output logic                              int_enable
);
   import cfrsc_pkg::*;

   cfrsc_sync_if sync ();

   cfrsc_state_e        state_q;
   cfrsc_state_e        state_d;
   logic [ADDR_W-1:0]   addr_q;
   logic [ADDR_W-1:0]   addr_d;
   logic [INSTR_W-1:0]  ir_q;
   logic [INSTR_W-1:0]  ir_d;
   logic                en_q;
   logic                en_d;
   logic                wr_q;
   logic                wr_d;
   logic                rd_q;
   logic                rd_d;
   logic                bank_q;
   logic                bank_d;
   logic                ie_q;
   logic                ie_d;
   logic [1:0]          cnt_q;
   logic [1:0]          cnt_d;
   logic                exec_q;
   logic                exec_d;

   // Pins pass two flops before the state machine reads them
   cfrsc_sync u_sync (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .reset_pin (reset_pin),
      .sleep_pin (sleep_pin),
      .sync      (sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Run state and start-up counter
   // FETCH is the cycle in which the memory reads addr_q; EXEC captures
   // the word and takes the next address, so one instruction spans two
   // cycles.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      if (sync.rst_req) begin
         state_d = CFRSC_RESET;
         cnt_d   = START_ZERO;
      end else begin
         case (state_q)
            CFRSC_RESET: begin
               // Fixed start-up order, same after every reset
               state_d = CFRSC_START;
               cnt_d   = START_ONE;
            end
            CFRSC_START: begin
               cnt_d = cnt_q + START_ONE;
               if (cnt_q == START_CYCLES - START_ONE) begin
                  state_d = CFRSC_FETCH;
               end
            end
            CFRSC_FETCH: begin
               state_d = CFRSC_EXEC;
            end
            CFRSC_EXEC: begin
               // Sleep is only honoured at the instruction boundary
               if (sync.sleep_req) begin
                  state_d = CFRSC_SLEEP;
               end else begin
                  state_d = CFRSC_FETCH;
               end
            end
            CFRSC_SLEEP: begin
               // Only reset, above, can disturb a sleeping core
               if (!sync.sleep_req) begin
                  state_d = CFRSC_FETCH;
               end
            end
            default: begin
               state_d = CFRSC_RESET;
            end
         endcase
      end
      exec_d = (state_d == CFRSC_EXEC);
   end

   // Start-up state held until the synchroniser lets go of reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= CFRSC_RESET;
         cnt_q   <= START_ZERO;
         exec_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         exec_q  <= exec_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch path: address, memory read enable and captured instruction.
   // The enable is high in the START and FETCH cycles, so the memory reads addr_q
   // at the end of FETCH and its word stands during EXEC.
   always_comb begin
      addr_d = addr_q;
      ir_d   = ir_q;
      en_d   = en_q;
      if (sync.rst_req) begin
         addr_d = RESET_ADDR;
         en_d   = 1'b0;
      end else begin
         case (state_q)
            CFRSC_RESET: begin
               // Memory enabled ahead of the first fetch
               en_d = 1'b1;
            end
            CFRSC_START: begin
               en_d = 1'b1;
            end
            CFRSC_FETCH: begin
               // One read per instruction keeps the memory idle in every EXEC cycle
               en_d = 1'b0;
            end
            CFRSC_EXEC: begin
               // Word for addr_q arrived at its read edge, one cycle before this capture
               ir_d   = instruction;
               addr_d = next_addr;
               en_d   = !sync.sleep_req;
            end
            CFRSC_SLEEP: begin
               // Enable returns with FETCH, so the held address is read in time
               en_d = !sync.sleep_req;
            end
            default: begin
               en_d = 1'b0;
            end
         endcase
      end
   end

   // Fetch path registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         addr_q <= RESET_ADDR;
         ir_q   <= '0;
         en_q   <= 1'b0;
      end else begin
         addr_q <= addr_d;
         ir_q   <= ir_d;
         en_q   <= en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobes: requests taken at the end of FETCH pulse for EXEC only;
   // reset, start-up and sleep all leave them low.
   always_comb begin
      wr_d = 1'b0;
      rd_d = 1'b0;
      if (!sync.rst_req && state_q == CFRSC_FETCH) begin
         wr_d = write_req;
         rd_d = read_req;
      end
   end

   // Strobe registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start-up context: bank A, interrupts off. Nothing here sets them again;
   // the instruction datapath owns any later change.
   always_comb begin
      bank_d = bank_q;
      ie_d   = ie_q;
      if (sync.rst_req) begin
         bank_d = 1'b0;
         ie_d   = 1'b0;
      end
   end

   // Start-up context registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bank_q <= 1'b0;
         ie_q   <= 1'b0;
      end else begin
         bank_q <= bank_d;
         ie_q   <= ie_d;
      end
   end

   // All outputs straight from flops
   assign address      = addr_q;
   assign bram_enable  = en_q;
   assign instr_word   = ir_q;
   assign exec_phase   = exec_q;
   assign write_strobe = wr_q;
   assign read_strobe  = rd_q;
   assign bank_sel     = bank_q;
   assign int_enable   = ie_q;
endmodule // cfrsc_top
